// ==== rtl/icgu_pkg.sv ====
package icgu_pkg;

  // register map, byte addresses on the bus
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MULT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SETTING = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;

  // control register fields
  localparam int unsigned CTRL_INT_ON_BIT = 0;
  localparam int unsigned CTRL_EXT_ON_BIT = 1;
  localparam int unsigned CTRL_BUS_EXT_BIT = 2;
  // configuration register fields
  localparam int unsigned CFG_STAY_ON_BIT = 0;
  localparam int unsigned CFG_EXT_PERMIT_BIT = 1;
  localparam int unsigned CFG_CRYSTAL_BIT = 2;
  // status register fields
  localparam int unsigned STAT_STABLE_BIT = 0;
  localparam int unsigned STAT_INT_EN_BIT = 1;
  localparam int unsigned STAT_EXT_EN_BIT = 2;
  localparam int unsigned STAT_STOP_BIT = 3;

  // reset values
  localparam logic RST_INT_ON = 1'b1;
  localparam logic [7:0] RST_MULT = 8'h08;
  localparam logic [11:0] RST_SETTING = 12'h500;

  // oscillator setting layout and limits
  localparam int unsigned SETTING_W = 12;
  localparam int unsigned STAGE_W = 8;
  localparam logic [3:0] DIV_SLOWEST = 4'h9;
  localparam logic [SETTING_W-1:0] SETTING_MAX = 12'h9FF;
  localparam logic [SETTING_W-1:0] STEP_LARGE = 12'h020;
  localparam logic [SETTING_W-1:0] STEP_MID = 12'h008;
  localparam logic [SETTING_W-1:0] STEP_SMALL = 12'h001;

  // oscillator model: half period in core cycles = minimum + setting >> shift
  localparam int unsigned NOMINAL_FREQ_HZ = 307200;
  localparam logic [8:0] DCO_MIN_HALF = 9'h002;
  localparam int unsigned DCO_RES_SHIFT = 4;

  // comparator error bands of the base clock against nominal
  localparam logic [2:0] BAND_BELOW_85 = 3'h0;
  localparam logic [2:0] BAND_BELOW_95 = 3'h1;
  localparam logic [2:0] BAND_BELOW_100 = 3'h2;
  localparam logic [2:0] BAND_BELOW_105 = 3'h3;
  localparam logic [2:0] BAND_BELOW_115 = 3'h4;
  localparam logic [2:0] BAND_ABOVE_115 = 3'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } icgu_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } icgu_axi_resp_type;

endpackage

// ==== rtl/icgu_clock_gen.sv ====
`timescale 1ns/1ps

// Behaviour
// RQ1 - bus clock runs at a quarter of oscillator clock, half of generator clock
// RQ2 - drive oscillator, generator and timebase clocks out to their consumers
// RQ3 - timebase takes external clock whenever available, else internal base clock
// RQ4 - software selects internal or external source for the bus clock
// RQ5 - stop mode with stay-on clear raises generator stop, halting all clocks
// RQ6 - stop mode with stay-on set keeps clocks running, no generator stop
// RQ7 - internal enable equals internal-on bit and not generator stop
// RQ8 - internal enable low turns oscillator off, internal and base clocks low
// RQ9 - external enable equals external-on and not stop; disabled external clock low
// RQ10 - external-on cannot be set unless external clock is permitted
// RQ11 - oscillator input pin port logic disabled whenever external-on set
// RQ12 - oscillator output pin port logic disabled when external-on and crystal set
// RQ13 - internal clock is integer multiple of base clock, factor from multiplier register
// RQ14 - base clock is internal clock divided by factor; factor 0 or 1 passes through
// RQ15 - oscillator period set by 12-bit setting, 4-bit divider field and 8-bit stage field, valid to 0x9FF
// RQ16 - comparator error outputs feed the loop filter as its corrections
// RQ17 - loop filter steps setting by 32, 8 or 1 up or down with carries
// RQ18 - divider field values 0xA to 0xF act as 0x9, slowest
// RQ19 - filter-stable flag set when base clock error below five percent
// RQ20 - at most one correction per base clock period, using that period's sample
module icgu_clock_gen
  import icgu_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire icgu_pkg::icgu_axi_req_type AXI_REQ_I,
  output icgu_pkg::icgu_axi_resp_type AXI_RESP_O,
  input wire logic STOP_MODE_I,
  input wire logic EXT_CLK_PIN_I,
  input wire logic [2:0] COMPARE_BAND_I,
  output logic OSC_OUT_CLK_O,
  output logic GEN_OUT_CLK_O,
  output logic BUS_CLK_O,
  output logic TIMEBASE_CLK_O,
  output logic INTERNAL_CLK_O,
  output logic BASE_CLK_O,
  output logic EXTERNAL_CLK_O,
  output logic GENERATOR_STOP_O,
  output logic INTERNAL_GEN_ENABLE_O,
  output logic EXTERNAL_GEN_ENABLE_O,
  output logic OSC_IN_PORT_ENABLE_O,
  output logic OSC_OUT_PORT_ENABLE_O,
  output logic FILTER_STABLE_FLAG_O
);
  import icgu_pkg::*;

  typedef struct packed {
    icgu_axi_resp_type axi;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic internal_on_bit;
    logic external_on_bit;
    logic bus_src_ext;
    logic stay_on_in_stop;
    logic external_clock_permit;
    logic crystal_select;
    logic [7:0] multiplier_reg;
    logic [SETTING_W-1:0] setting;
    logic [2:0] ext_sync;
    logic ext_filt;
    logic [2:0] band_s1;
    logic [2:0] band_s2;
    logic [2:0] band_s3;
    logic [2:0] band_filt;
    logic generator_stop;
    logic internal_gen_enable;
    logic external_gen_enable;
    logic osc_in_port_enable;
    logic osc_out_port_enable;
    logic [8:0] dco_cnt;
    logic internal_clock;
    logic [7:0] mod_cnt;
    logic base_clock;
    logic external_clock;
    logic osc_clk;
    logic gen_clk;
    logic bus_clk;
    logic timebase_clk;
    logic filter_stable_flag;
  } icgu_state_type;

  localparam icgu_state_type STATE_RESET = '{
    axi: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    internal_on_bit: RST_INT_ON,
    multiplier_reg: RST_MULT,
    setting: RST_SETTING,
    osc_in_port_enable: 1'b1,
    osc_out_port_enable: 1'b1,
    internal_gen_enable: RST_INT_ON,
    default: '0
  };

  icgu_state_type s_reg;
  icgu_state_type s_next;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb
  begin
    logic [31:0] ctrl_word;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    logic [31:0] wr_word;
    logic [3:0] div_eff;
    logic [8:0] half_period;
    logic int_rise;
    logic osc_rise;
    logic gen_rise;
    logic base_rise;
    logic [7:0] half_n;
    s_next = s_reg;
    ctrl_word = '0;
    ctrl_word[CTRL_INT_ON_BIT] = s_reg.internal_on_bit;
    ctrl_word[CTRL_EXT_ON_BIT] = s_reg.external_on_bit;
    ctrl_word[CTRL_BUS_EXT_BIT] = s_reg.bus_src_ext;
    cfg_word = '0;
    cfg_word[CFG_STAY_ON_BIT] = s_reg.stay_on_in_stop;
    cfg_word[CFG_EXT_PERMIT_BIT] = s_reg.external_clock_permit;
    cfg_word[CFG_CRYSTAL_BIT] = s_reg.crystal_select;
    stat_word = '0;
    stat_word[STAT_STABLE_BIT] = s_reg.filter_stable_flag;
    stat_word[STAT_INT_EN_BIT] = s_reg.internal_gen_enable;
    stat_word[STAT_EXT_EN_BIT] = s_reg.external_gen_enable;
    stat_word[STAT_STOP_BIT] = s_reg.generator_stop;
    wr_word = '0;
    div_eff = '0;
    half_period = '0;
    int_rise = 1'b0;
    osc_rise = 1'b0;
    gen_rise = 1'b0;
    base_rise = 1'b0;
    half_n = '0;

    // write channels taken independently, answered once both are held
    if (AXI_REQ_I.awvalid && s_reg.axi.awready)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = AXI_REQ_I.awaddr;
    end
    if (AXI_REQ_I.wvalid && s_reg.axi.wready)
    begin
      s_next.w_have = 1'b1;
      s_next.w_data = AXI_REQ_I.wdata;
      s_next.w_strb = AXI_REQ_I.wstrb;
    end
    if (s_reg.axi.bvalid && AXI_REQ_I.bready)
    begin
      s_next.axi.bvalid = 1'b0;
    end
    if (s_reg.aw_have && s_reg.w_have && !s_reg.axi.bvalid)
    begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.axi.bvalid = 1'b1;
      s_next.axi.bresp = RESP_OKAY;
      case (s_reg.aw_addr)
        ADDR_CTRL:
        begin
          wr_word = merge_bytes(ctrl_word, s_reg.w_data, s_reg.w_strb);
          s_next.internal_on_bit = wr_word[CTRL_INT_ON_BIT];
          // a set is only honoured while permitted; clearing always works
          s_next.external_on_bit = wr_word[CTRL_EXT_ON_BIT]
                                   & (s_reg.external_clock_permit | s_reg.external_on_bit); // [RQ10]
          s_next.bus_src_ext = wr_word[CTRL_BUS_EXT_BIT]; // [RQ4]
        end
        ADDR_CONFIG:
        begin
          wr_word = merge_bytes(cfg_word, s_reg.w_data, s_reg.w_strb);
          s_next.stay_on_in_stop = wr_word[CFG_STAY_ON_BIT];
          s_next.external_clock_permit = wr_word[CFG_EXT_PERMIT_BIT];
          s_next.crystal_select = wr_word[CFG_CRYSTAL_BIT];
        end
        ADDR_MULT:
        begin
          wr_word = merge_bytes({24'h000000, s_reg.multiplier_reg}, s_reg.w_data, s_reg.w_strb);
          s_next.multiplier_reg = wr_word[7:0]; // [RQ13]
        end
        ADDR_SETTING:
        begin
          wr_word = merge_bytes({20'h00000, s_reg.setting}, s_reg.w_data, s_reg.w_strb);
          s_next.setting = wr_word[SETTING_W-1:0];
        end
        ADDR_STATUS:
        begin
          s_next.axi.bresp = RESP_OKAY;
        end
        default:
        begin
          s_next.axi.bresp = RESP_DECERR;
        end
      endcase
    end
    s_next.axi.awready = !s_next.aw_have && !s_next.axi.bvalid;
    s_next.axi.wready = !s_next.w_have && !s_next.axi.bvalid;

    if (s_reg.axi.rvalid && AXI_REQ_I.rready)
    begin
      s_next.axi.rvalid = 1'b0;
      s_next.axi.arready = 1'b1;
    end
    if (AXI_REQ_I.arvalid && s_reg.axi.arready)
    begin
      s_next.axi.arready = 1'b0;
      s_next.axi.rvalid = 1'b1;
      s_next.axi.rresp = RESP_OKAY;
      case (AXI_REQ_I.araddr)
        ADDR_CTRL: s_next.axi.rdata = ctrl_word;
        ADDR_CONFIG: s_next.axi.rdata = cfg_word;
        ADDR_MULT: s_next.axi.rdata = {24'h000000, s_reg.multiplier_reg};
        ADDR_SETTING: s_next.axi.rdata = {20'h00000, s_reg.setting};
        ADDR_STATUS: s_next.axi.rdata = stat_word;
        default:
        begin
          s_next.axi.rdata = '0;
          s_next.axi.rresp = RESP_DECERR;
        end
      endcase
    end

    // pin and analog inputs: three stages, change accepted when stages two and three agree
    s_next.ext_sync = {s_reg.ext_sync[1:0], EXT_CLK_PIN_I};
    if (s_reg.ext_sync[1] == s_reg.ext_sync[2])
    begin
      s_next.ext_filt = s_reg.ext_sync[2];
    end
    s_next.band_s1 = COMPARE_BAND_I;
    s_next.band_s2 = s_reg.band_s1;
    s_next.band_s3 = s_reg.band_s2;
    if (s_reg.band_s2 == s_reg.band_s3)
    begin
      s_next.band_filt = s_reg.band_s3; // [RQ16]
    end

    // enable circuit
    s_next.generator_stop = STOP_MODE_I && !s_reg.stay_on_in_stop; // [RQ5] [RQ6]
    s_next.internal_gen_enable = s_reg.internal_on_bit && !s_next.generator_stop; // [RQ7]
    s_next.external_gen_enable = s_reg.external_on_bit && !s_next.generator_stop; // [RQ9]
    // port enables deliberately ignore stop so pins stay claimed in stop mode
    s_next.osc_in_port_enable = !s_reg.external_on_bit; // [RQ11]
    s_next.osc_out_port_enable = !(s_reg.external_on_bit && s_reg.crystal_select); // [RQ12]
    s_next.external_clock = s_reg.external_gen_enable && s_reg.ext_filt; // [RQ9]

    // oscillator: out-of-range divider field behaves as the slowest value
    div_eff = (s_reg.setting[SETTING_W-1:STAGE_W] > DIV_SLOWEST) ? DIV_SLOWEST
              : s_reg.setting[SETTING_W-1:STAGE_W]; // [RQ18]
    half_period = DCO_MIN_HALF + {1'b0, 8'({div_eff, s_reg.setting[STAGE_W-1:0]} >> DCO_RES_SHIFT)}; // [RQ15]
    half_n = s_reg.multiplier_reg >> 1;
    if (!s_reg.internal_gen_enable)
    begin
      s_next.dco_cnt = '0;
      s_next.internal_clock = 1'b0; // [RQ8]
      s_next.mod_cnt = '0;
      s_next.base_clock = 1'b0; // [RQ8]
    end
    else
    begin
      if (s_reg.dco_cnt >= half_period - 9'h001)
      begin
        s_next.dco_cnt = '0;
        s_next.internal_clock = !s_reg.internal_clock;
        int_rise = !s_reg.internal_clock;
      end
      else
      begin
        s_next.dco_cnt = s_reg.dco_cnt + 9'h001;
      end
      if (s_reg.multiplier_reg <= 8'h01)
      begin
        s_next.base_clock = s_next.internal_clock; // [RQ14]
      end
      else if (int_rise)
      begin
        s_next.mod_cnt = (s_reg.mod_cnt >= s_reg.multiplier_reg - 8'h01) ? 8'h00 : s_reg.mod_cnt + 8'h01;
        s_next.base_clock = s_next.mod_cnt < half_n; // [RQ13] [RQ14]
      end
      base_rise = s_next.base_clock && !s_reg.base_clock;
    end

    // loop filter: one correction per base period, from that period's band
    if (base_rise)
    begin
      case (s_reg.band_filt) // [RQ20]
        BAND_BELOW_85: s_next.setting = s_reg.setting - STEP_LARGE; // [RQ17]
        BAND_BELOW_95: s_next.setting = s_reg.setting - STEP_MID;
        BAND_BELOW_100: s_next.setting = s_reg.setting - STEP_SMALL;
        BAND_BELOW_105: s_next.setting = s_reg.setting + STEP_SMALL;
        BAND_BELOW_115: s_next.setting = s_reg.setting + STEP_MID;
        BAND_ABOVE_115: s_next.setting = s_reg.setting + STEP_LARGE;
        // no step: a software write in this cycle must not be lost
        default: ;
      endcase
      s_next.filter_stable_flag = (s_reg.band_filt == BAND_BELOW_100)
                                  || (s_reg.band_filt == BAND_BELOW_105); // [RQ19]
    end

    // output clocks; halving stages keep the ratios exact
    s_next.osc_clk = s_reg.bus_src_ext ? s_reg.external_clock : s_reg.internal_clock; // [RQ4] [RQ2]
    osc_rise = s_next.osc_clk && !s_reg.osc_clk;
    if (osc_rise)
    begin
      s_next.gen_clk = !s_reg.gen_clk; // [RQ1]
    end
    gen_rise = s_next.gen_clk && !s_reg.gen_clk;
    if (gen_rise)
    begin
      s_next.bus_clk = !s_reg.bus_clk; // [RQ1]
    end
    s_next.timebase_clk = s_reg.external_gen_enable ? s_reg.external_clock : s_reg.base_clock; // [RQ3] [RQ2]
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      s_reg <= STATE_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign AXI_RESP_O = s_reg.axi;
  assign OSC_OUT_CLK_O = s_reg.osc_clk;
  assign GEN_OUT_CLK_O = s_reg.gen_clk;
  assign BUS_CLK_O = s_reg.bus_clk;
  assign TIMEBASE_CLK_O = s_reg.timebase_clk;
  assign INTERNAL_CLK_O = s_reg.internal_clock;
  assign BASE_CLK_O = s_reg.base_clock;
  assign EXTERNAL_CLK_O = s_reg.external_clock;
  assign GENERATOR_STOP_O = s_reg.generator_stop;
  assign INTERNAL_GEN_ENABLE_O = s_reg.internal_gen_enable;
  assign EXTERNAL_GEN_ENABLE_O = s_reg.external_gen_enable;
  assign OSC_IN_PORT_ENABLE_O = s_reg.osc_in_port_enable;
  assign OSC_OUT_PORT_ENABLE_O = s_reg.osc_out_port_enable;
  assign FILTER_STABLE_FLAG_O = s_reg.filter_stable_flag;

endmodule

// ==== test/icgu_chk.sv ====
`timescale 1ns/1ps
module icgu_chk
(
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic STOP_MODE_I,
  input wire logic INTERNAL_CLK_O,
  input wire logic BASE_CLK_O,
  input wire logic EXTERNAL_CLK_O,
  input wire logic TIMEBASE_CLK_O,
  input wire logic GENERATOR_STOP_O,
  input wire logic INTERNAL_GEN_ENABLE_O,
  input wire logic EXTERNAL_GEN_ENABLE_O,
  input wire logic OSC_IN_PORT_ENABLE_O,
  input wire logic OSC_OUT_PORT_ENABLE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_stop; !STOP_MODE_I |=> !GENERATOR_STOP_O; endproperty
  a_stop: assert property (p_stop) else $error("stop raised without stop mode");
  property p_int_gate; GENERATOR_STOP_O |-> !INTERNAL_GEN_ENABLE_O; endproperty
  a_int_gate: assert property (p_int_gate) else $error("internal enable during stop");
  property p_ext_gate; GENERATOR_STOP_O |-> !EXTERNAL_GEN_ENABLE_O; endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external enable during stop");
  property p_int_low; !INTERNAL_GEN_ENABLE_O [*3] |-> !INTERNAL_CLK_O && !BASE_CLK_O; endproperty
  a_int_low: assert property (p_int_low) else $error("internal clocks run while disabled");
  property p_ext_low; !EXTERNAL_GEN_ENABLE_O [*3] |-> !EXTERNAL_CLK_O; endproperty
  a_ext_low: assert property (p_ext_low) else $error("external clock runs while disabled");
  // timebase may lag the external clock by one register stage
  property p_tb_ext;
    EXTERNAL_GEN_ENABLE_O [*3] ##0 $rose(TIMEBASE_CLK_O) |-> EXTERNAL_CLK_O || $past(EXTERNAL_CLK_O);
  endproperty
  a_tb_ext: assert property (p_tb_ext) else $error("timebase not from external clock");
  property p_port_stop;
    $rose(GENERATOR_STOP_O) |=> $stable(OSC_IN_PORT_ENABLE_O) && $stable(OSC_OUT_PORT_ENABLE_O);
  endproperty
  a_port_stop: assert property (p_port_stop) else $error("port enable moved with stop");
  property p_port_pair; !OSC_OUT_PORT_ENABLE_O |-> !OSC_IN_PORT_ENABLE_O; endproperty
  a_port_pair: assert property (p_port_pair) else $error("output pin freed alone");
endmodule

bind icgu_clock_gen icgu_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .STOP_MODE_I(STOP_MODE_I),
  .INTERNAL_CLK_O(INTERNAL_CLK_O), .BASE_CLK_O(BASE_CLK_O), .EXTERNAL_CLK_O(EXTERNAL_CLK_O),
  .TIMEBASE_CLK_O(TIMEBASE_CLK_O), .GENERATOR_STOP_O(GENERATOR_STOP_O),
  .INTERNAL_GEN_ENABLE_O(INTERNAL_GEN_ENABLE_O), .EXTERNAL_GEN_ENABLE_O(EXTERNAL_GEN_ENABLE_O),
  .OSC_IN_PORT_ENABLE_O(OSC_IN_PORT_ENABLE_O), .OSC_OUT_PORT_ENABLE_O(OSC_OUT_PORT_ENABLE_O));

// ==== test/icgu_far_end.sv ====
`timescale 1ns/1ps
module icgu_far_end
(
  input wire logic run_i,
  input wire logic [2:0] band_i,
  output logic pin_o,
  output logic [2:0] band_o
);
  initial pin_o = 1'b0;
  initial band_o = 3'h6;
  // source period not a multiple of the core clock, so phases drift
  always #25 pin_o = run_i ? ~pin_o : 1'b0;
  // comparator result settles with skew against the core clock
  always @(band_i) band_o <= #3 band_i;
endmodule

// ==== test/test_internal_clock_generator_enable.sv ====
`timescale 1ns/1ps
module test_internal_clock_generator_enable;
  import icgu_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic smode = 1'b0;
  logic run = 1'b0;
  logic [2:0] band = 3'h6;
  logic pin, osc, gen, bus, tb, ick, bas, eck, gst, ien, een, pie, poe, stb;
  logic [2:0] bw;
  icgu_axi_req_type q = '0;
  icgu_axi_resp_type s;
  int n_errors = 0;
  int tests_run = 0;
  int mdl [4] = '{32'h1, 32'h0, 32'h8, 32'h500};
  int stp [6] = '{-32, -8, -1, 1, 8, 32};
  int nv [4] = '{0, 1, 2, 0};
  logic [11:0] sv [5] = '{12'h000, 12'h9FF, 12'hA00, 12'hF55, 12'h000};
  int c [7];
  int hi, r, p, e;
  always #4 clk = ~clk;
  icgu_far_end u_far (.run_i(run), .band_i(band), .pin_o(pin), .band_o(bw));
  icgu_clock_gen u_dut (.CORE_CLK_I(clk), .RESETN_I(rstn), .AXI_REQ_I(q), .AXI_RESP_O(s), .STOP_MODE_I(smode),
    .EXT_CLK_PIN_I(pin), .COMPARE_BAND_I(bw), .OSC_OUT_CLK_O(osc), .GEN_OUT_CLK_O(gen), .BUS_CLK_O(bus),
    .TIMEBASE_CLK_O(tb), .INTERNAL_CLK_O(ick), .BASE_CLK_O(bas), .EXTERNAL_CLK_O(eck), .GENERATOR_STOP_O(gst),
    .INTERNAL_GEN_ENABLE_O(ien), .EXTERNAL_GEN_ENABLE_O(een), .OSC_IN_PORT_ENABLE_O(pie),
    .OSC_OUT_PORT_ENABLE_O(poe), .FILTER_STABLE_FLAG_O(stb));
  task automatic summarize();
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic near(input string nm, input int a, input int b);
    chk(nm, b > 0 && a - b <= 2 && b - a <= 2, 1'b1);
  endtask
  task automatic stuck();
    chk("wait", 1'b0, 1'b1);
    summarize();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a inside {ADDR_CTRL, ADDR_CONFIG, ADDR_MULT, ADDR_SETTING, ADDR_STATUS}) ? RESP_OKAY : RESP_DECERR;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    q.awvalid <= 1'b1;
    q.awaddr <= a;
    q.wvalid <= 1'b1;
    q.wdata <= d;
    q.wstrb <= 4'hF;
    q.bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s.bvalid)
        break;
      if (q.awvalid && s.awready)
        q.awvalid <= 1'b0;
      if (q.wvalid && s.wready)
        q.wvalid <= 1'b0;
    end
    q.bready <= 1'b0;
    if (n == 50)
      stuck();
    chk("bresp", s.bresp, resp_of(a));
    // ext-on cannot be newly set without permit
    if (a == ADDR_CTRL)
      mdl[0] = (mdl[1][1] || mdl[0][1]) ? d & 32'h7 : d & 32'h5;
    if (a == ADDR_CONFIG)
      mdl[1] = d & 32'h7;
    if (a == ADDR_MULT)
      mdl[2] = d & 32'hFF;
    if (a == ADDR_SETTING)
      mdl[3] = d & 32'hFFF;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int n;
    @(posedge clk);
    q.arvalid <= 1'b1;
    q.araddr <= a;
    q.rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s.rvalid)
        break;
      if (q.arvalid && s.arready)
        q.arvalid <= 1'b0;
    end
    q.rready <= 1'b0;
    if (n == 50)
      stuck();
    chk("rdata", s.rdata, exp);
    chk("rresp", s.rresp, resp_of(a));
  endtask
  task automatic watch(input int cyc);
    logic [6:0] pv, nw;
    tick(8);
    c = '{default: 0};
    hi = 0;
    pv = {osc, gen, bus, tb, eck, ick, bas};
    repeat (cyc)
    begin
      @(posedge clk);
      nw = {osc, gen, bus, tb, eck, ick, bas};
      for (int k = 0; k < 7; k++)
        c[k] += nw[k] && !pv[k];
      pv = nw;
      hi += ick || bas || eck;
    end
  endtask
  // counts only the last of the wanted base periods
  task automatic meas(input int want);
    int st;
    logic pb, pi;
    st = 0;
    r = 0;
    p = 0;
    pb = bas;
    pi = ick;
    for (int n = 0; n < 40000 && st < want; n++)
    begin
      @(posedge clk);
      if (st == want - 1)
      begin
        p++;
        r += ick && !pi;
      end
      st += bas && !pb;
      pb = bas;
      pi = ick;
    end
    if (st < want)
      stuck();
  endtask
  initial
  begin
    void'($urandom(32'hF778BF11));
    sv[4] = 12'($urandom_range(12'h9FF));
    nv[3] = $urandom_range(16, 3);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    chk("pins", {ien, een, pie, poe}, 4'b1011);
    for (int i = 0; i < 4; i++)
      rd(ADDR_CTRL + 8'(4 * i), mdl[i]);
    rd(ADDR_STATUS, 32'h2);
    rd(8'h14, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    wr(ADDR_STATUS, 32'hF);
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_CTRL, mdl[0]);
    wr(ADDR_CONFIG, 32'h2);
    wr(ADDR_CTRL, 32'h3);
    tick(2);
    chk("pins", {een, pie, poe}, 3'b101);
    wr(ADDR_CONFIG, 32'h6);
    tick(2);
    chk("pins", {een, pie, poe}, 3'b100);
    wr(ADDR_CONFIG, 32'h2);
    wr(ADDR_SETTING, 32'h0);
    wr(ADDR_MULT, 32'h0);
    run <= 1'b1;
    watch(2000);
    near("osc", c[6], c[1]);
    near("gen", 2 * c[5], c[6]);
    near("bus", 4 * c[4], c[6]);
    near("tb", c[3], c[2]);
    wr(ADDR_CTRL, 32'h7);
    watch(2000);
    near("osc", c[6], c[2]);
    wr(ADDR_CTRL, 32'h1);
    watch(2000);
    near("tb", c[3], c[0]);
    chk("external_clock", c[2], 32'h0);
    wr(ADDR_CTRL, 32'h3);
    smode <= 1'b1;
    tick(4);
    chk("stop", {gst, ien, een, pie}, 4'b1000);
    rd(ADDR_STATUS, 32'h8);
    watch(200);
    chk("held", hi, 32'h0);
    wr(ADDR_CONFIG, 32'h3);
    tick(4);
    chk("stay", {gst, ien, een}, 3'b011);
    watch(500);
    chk("run", c[1] > 0 && c[2] > 0, 1'b1);
    smode <= 1'b0;
    foreach (sv[i])
    begin
      wr(ADDR_SETTING, sv[i]);
      meas(3);
      e = (sv[i][11:8] > 4'h9) ? 32'h900 + sv[i][7:0] : sv[i];
      chk("period", p, 2 * (DCO_MIN_HALF + (e >> DCO_RES_SHIFT)));
    end
    wr(ADDR_SETTING, 32'h0);
    foreach (nv[i])
    begin
      wr(ADDR_MULT, nv[i]);
      meas(3);
      e = nv[i] > 1 ? nv[i] : 1;
      chk("ratio", r, e);
      chk("base", p, 2 * DCO_MIN_HALF * e);
    end
    wr(ADDR_MULT, 32'h0);
    foreach (stp[b])
    begin
      e = b < 3 ? 32'h200 : 32'h1FC;
      wr(ADDR_SETTING, e);
      meas(1);
      band <= 3'(b);
      meas(1);
      band <= 3'h6;
      tick(3);
      chk("stable", stb, b == 2 || b == 3);
      rd(ADDR_SETTING, (e + stp[b]) & 32'hFFF);
    end
    summarize();
  end
endmodule
